/* File: hw/nvu_defines.svh */
// register offsets, field positions, key values and reset values for the unlock control
// How it works
// RQ1: software masks interrupts below priority 7 for five instructions before unlocking.
// RQ2: first unlock step writes byte 0x55 to the key register.
// RQ3: the very next key write must be 0xAA to complete the unlock.
// RQ4: setting start right after the unlock pair begins the selected operation; the code also needs write enable set by an earlier write.
// RQ5: software follows the start instruction with exactly two no-operations.
// RQ6: control holds start bit15, write enable bit14, error bit13, type low bits; reset zero.
// RQ7: address low and upper low byte undefined after reset; upper byte reads zero.
// RQ8: device clears start by itself when the operation finishes.
// RQ9: key register is write-only and needs both values in consecutive writes.
// RQ10: address registers capture the 24-bit table address, low 16 and upper 8.
// RQ11: broken or wrong key sequence ignores start and needs the full key again.
`ifndef NVU_DEFINES_SVH
`define NVU_DEFINES_SVH
`define NVU_OFS_CONTROL 16'h0760
`define NVU_OFS_ADDR_LOW 16'h0762
`define NVU_OFS_ADDR_UPPER 16'h0764
`define NVU_OFS_KEY 16'h0766
`define NVU_OFS_IRQ_STATUS 16'h0768
`define NVU_OFS_IRQ_MASK 16'h076C
`define NVU_BIT_START 15
`define NVU_BIT_WRITE_ENABLE_BIT 14
`define NVU_BIT_WRITE_ERROR_FLAG 13
`define NVU_TYPE_W 4
`define NVU_KEY_FIRST 8'h55
`define NVU_KEY_SECOND 8'hAA
`define NVU_CONTROL_RESET 16'h0000
`define NVU_IRQ_DONE 0
`define NVU_IRQ_KEYFAIL 1
`endif

/* File: hw/nvu_pkg.sv */
// types for the nonvolatile unlock control block
package nvu_pkg;
  typedef enum logic [1:0] {
    NVU_LOCKED = 2'b00,
    NVU_HALF = 2'b01,
    NVU_UNLOCKED = 2'b10,
    NVU_BUSY = 2'b11
  } nvu_state_t;

  typedef struct packed {
    nvu_state_t st;
    logic start;
    logic write_enable_bit;
    logic write_error_flag;
    logic [3:0] optype;
    logic [15:0] addr_low;
    logic [7:0] addr_up;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [31:0] rdata;
    logic rvalid;
  } nvu_regs_t;
endpackage : nvu_pkg

/* File: hw/nvu_unlock_control.sv */
// unlock, start and register map of the nonvolatile memory sequencer
`timescale 1ns/1ps
`include "nvu_defines.svh"
module nvu_unlock_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic tbl_valid,
  input wire logic [23:0] tbl_address,
  input wire logic op_done,
  input wire logic abort_reset,
  output logic op_start,
  output logic [3:0] op_type,
  output logic irq
);
  import nvu_pkg::*;

  nvu_regs_t s_r;
  nvu_regs_t s_nxt;
  logic wr_ctl;
  logic wr_key;
  logic [7:0] key_byte;
  logic [15:0] ctl_read;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // reads answer one cycle late; writes are taken at once
  assign avs_waitrequest = avs_read && !s_r.rvalid;
  assign avs_readdata = s_r.rdata;
  assign wr_ctl = avs_write && hit(avs_address, `NVU_OFS_CONTROL) && avs_byteenable[1];
  assign wr_key = avs_write && hit(avs_address, `NVU_OFS_KEY) && avs_byteenable[0];
  assign key_byte = avs_writedata[7:0];
  assign ctl_read = {s_r.start, s_r.write_enable_bit, s_r.write_error_flag, 9'h000, s_r.optype}; // [RQ6]
  assign op_type = s_r.optype;
  assign irq = |(s_r.irq_status & s_r.irq_mask);

  always_comb
  begin
    s_nxt = s_r;
    op_start = 1'b0;
    s_nxt.rvalid = 1'b0;
    if (tbl_valid)
    begin
      s_nxt.addr_low = tbl_address[15:0]; // [RQ10]
      s_nxt.addr_up = tbl_address[23:16]; // [RQ10]
    end
    // key tracker: any write other than the expected next key drops the unlock
    case (s_r.st)
      NVU_LOCKED:
      begin
        if (wr_key && key_byte == `NVU_KEY_FIRST)
        begin
          s_nxt.st = NVU_HALF; // [RQ2]
        end
      end
      NVU_HALF:
      begin
        if (wr_key && key_byte == `NVU_KEY_SECOND)
        begin
          s_nxt.st = NVU_UNLOCKED; // [RQ3] [RQ9]
        end
        else if (avs_write)
        begin
          s_nxt.st = NVU_LOCKED; // [RQ11]
          s_nxt.irq_status[`NVU_IRQ_KEYFAIL] = 1'b1;
        end
      end
      NVU_UNLOCKED:
      begin
        if (avs_write)
        begin
          s_nxt.st = NVU_LOCKED; // [RQ11]
          // start needs write enable set by an earlier write
          if (wr_ctl && avs_writedata[`NVU_BIT_START] && s_r.write_enable_bit)
          begin
            s_nxt.st = NVU_BUSY; // [RQ4]
            s_nxt.start = 1'b1;
            op_start = 1'b1;
          end
        end
      end
      NVU_BUSY:
      begin
        if (abort_reset)
        begin
          s_nxt.st = NVU_LOCKED;
          s_nxt.start = 1'b0;
          s_nxt.write_error_flag = 1'b1;
        end
        else if (op_done)
        begin
          s_nxt.st = NVU_LOCKED;
          s_nxt.start = 1'b0; // [RQ8]
          s_nxt.irq_status[`NVU_IRQ_DONE] = 1'b1;
        end
      end
      default:
      begin
        s_nxt.st = NVU_LOCKED;
      end
    endcase
    if (wr_ctl)
    begin
      // software can never clear start; only abort_reset or reset cuts a running operation short
      s_nxt.write_enable_bit = avs_writedata[`NVU_BIT_WRITE_ENABLE_BIT];
      // an abort in this very cycle keeps the error flag set only if the flag was clear before
      s_nxt.write_error_flag = avs_writedata[`NVU_BIT_WRITE_ERROR_FLAG] | (s_nxt.write_error_flag & ~s_r.write_error_flag);
      if (s_r.st != NVU_BUSY)
      begin
        s_nxt.optype = avs_writedata[`NVU_TYPE_W-1:0];
      end
    end
    if (avs_write && hit(avs_address, `NVU_OFS_ADDR_LOW) && avs_byteenable[1:0] == 2'b11)
    begin
      s_nxt.addr_low = avs_writedata[15:0];
    end
    if (avs_write && hit(avs_address, `NVU_OFS_ADDR_UPPER) && avs_byteenable[0])
    begin
      s_nxt.addr_up = avs_writedata[7:0];
    end
    if (avs_write && hit(avs_address, `NVU_OFS_IRQ_MASK))
    begin
      s_nxt.irq_mask = avs_writedata[1:0];
    end
    if (avs_write && hit(avs_address, `NVU_OFS_IRQ_STATUS))
    begin
      // a bit newly set by this cycle's events wins over the write-one clear; one already set is cleared
      s_nxt.irq_status = s_nxt.irq_status &
        ~(avs_writedata[1:0] & ~(s_nxt.irq_status & ~s_r.irq_status));
    end
    if (avs_read && !s_r.rvalid)
    begin
      s_nxt.rvalid = 1'b1;
      case (avs_address)
        `NVU_OFS_CONTROL: s_nxt.rdata = {16'h0000, ctl_read};
        `NVU_OFS_ADDR_LOW: s_nxt.rdata = {16'h0000, s_r.addr_low};
        `NVU_OFS_ADDR_UPPER: s_nxt.rdata = {24'h000000, s_r.addr_up}; // [RQ7]
        `NVU_OFS_IRQ_STATUS: s_nxt.rdata = {30'h00000000, s_r.irq_status};
        `NVU_OFS_IRQ_MASK: s_nxt.rdata = {30'h00000000, s_r.irq_mask};
        default: s_nxt.rdata = 32'h00000000; // key register reads zero [RQ9]
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r.st <= NVU_LOCKED;
      s_r.start <= 1'b0; // [RQ6]
      s_r.write_enable_bit <= 1'b0;
      s_r.write_error_flag <= 1'b0;
      s_r.optype <= 4'h0;
      s_r.irq_status <= 2'h0;
      s_r.irq_mask <= 2'h0;
      s_r.rdata <= 32'h00000000;
      s_r.rvalid <= 1'b0;
      // address registers are left as they were [RQ7]
    end
    else
    begin
      s_r <= s_nxt;
    end
    if (!reset)
    begin
      s_r.addr_low <= s_nxt.addr_low;
      s_r.addr_up <= s_nxt.addr_up;
    end
  end

  // key sequence: the state alone remembers that the last write was the second key
  AST_START_NEEDS_KEY: assert property (@(posedge clk) disable iff (reset) // [RQ3]
    op_start
    |-> s_r.st == NVU_UNLOCKED && wr_ctl)
    else $error("start without full key");

  AST_HALF_AFTER_55: assert property (@(posedge clk) disable iff (reset) // [RQ2]
    (s_r.st == NVU_LOCKED && wr_key && key_byte == `NVU_KEY_FIRST)
    |=> s_r.st == NVU_HALF)
    else $error("first key not taken");

  AST_LOCKED_STAYS: assert property (@(posedge clk) disable iff (reset) // [RQ2]
    (s_r.st == NVU_LOCKED && !(wr_key && key_byte == `NVU_KEY_FIRST))
    |=> s_r.st == NVU_LOCKED)
    else $error("left lock without first key");

  AST_HALF_TO_UNLOCK: assert property (@(posedge clk) disable iff (reset) // [RQ3]
    (s_r.st == NVU_HALF && wr_key && key_byte == `NVU_KEY_SECOND)
    |=> s_r.st == NVU_UNLOCKED)
    else $error("second key not taken");

  AST_BAD_KEY_LOCKS: assert property (@(posedge clk) disable iff (reset) // [RQ11]
    (s_r.st == NVU_HALF && avs_write && !(wr_key && key_byte == `NVU_KEY_SECOND))
    |=> s_r.st == NVU_LOCKED)
    else $error("bad key did not relock");

  AST_KEYFAIL_SET: assert property (@(posedge clk) disable iff (reset) // [RQ11]
    (s_r.st == NVU_HALF && avs_write && !(wr_key && key_byte == `NVU_KEY_SECOND))
    |=> s_r.irq_status[`NVU_IRQ_KEYFAIL])
    else $error("key failure not flagged");

  AST_UNLOCK_ONE_WRITE: assert property (@(posedge clk) disable iff (reset) // [RQ11]
    (s_r.st == NVU_UNLOCKED && avs_write && !op_start)
    |=> s_r.st == NVU_LOCKED)
    else $error("unlock survived another write");

  AST_NO_START_LOCKED: assert property (@(posedge clk) disable iff (reset) // [RQ11]
    (s_r.st != NVU_UNLOCKED)
    |-> !op_start)
    else $error("start while locked");

  // start and completion
  AST_START_NEEDS_WRITE_ENABLE_BIT: assert property (@(posedge clk) disable iff (reset) // [RQ4]
    op_start
    |-> s_r.write_enable_bit && avs_writedata[`NVU_BIT_START])
    else $error("start without write enable");

  AST_START_SETS: assert property (@(posedge clk) disable iff (reset) // [RQ4]
    op_start
    |=> s_r.start && s_r.st == NVU_BUSY)
    else $error("start bit not set");

  AST_START_MEANS_BUSY: assert property (@(posedge clk) disable iff (reset) // [RQ8]
    s_r.start
    |-> s_r.st == NVU_BUSY)
    else $error("start bit outside an operation");

  AST_BUSY_HOLDS_START: assert property (@(posedge clk) disable iff (reset) // [RQ8]
    (s_r.st == NVU_BUSY && !op_done && !abort_reset)
    |=> s_r.start && s_r.st == NVU_BUSY)
    else $error("operation ended early");

  AST_DONE_CLEARS: assert property (@(posedge clk) disable iff (reset) // [RQ8]
    (s_r.st == NVU_BUSY && op_done && !abort_reset)
    |=> !s_r.start)
    else $error("start not cleared at done");

  AST_DONE_IRQ: assert property (@(posedge clk) disable iff (reset) // [RQ8]
    (s_r.st == NVU_BUSY && op_done && !abort_reset)
    |=> s_r.irq_status[`NVU_IRQ_DONE])
    else $error("done not flagged");

  AST_ABORT_ERROR: assert property (@(posedge clk) disable iff (reset) // [RQ6]
    (s_r.st == NVU_BUSY && abort_reset)
    |=> s_r.write_error_flag && !s_r.start)
    else $error("abort did not set error");

  AST_TYPE_FROZEN: assert property (@(posedge clk) disable iff (reset) // [RQ6]
    (s_r.st == NVU_BUSY)
    |=> $stable(op_type))
    else $error("type changed while busy");

  AST_WRITE_ENABLE_BIT_WRITE: assert property (@(posedge clk) disable iff (reset) // [RQ6]
    wr_ctl
    |=> s_r.write_enable_bit == $past(avs_writedata[`NVU_BIT_WRITE_ENABLE_BIT]))
    else $error("write enable not stored");

  // address capture and register reads
  AST_ADDR_CAPTURE: assert property (@(posedge clk) disable iff (reset) // [RQ10]
    (tbl_valid && !avs_write)
    |=> {s_r.addr_up, s_r.addr_low} == $past(tbl_address))
    else $error("address not captured");

  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (reset) // [RQ7]
    (avs_read && avs_address == `NVU_OFS_ADDR_UPPER && !s_r.rvalid)
    |=> avs_readdata[31:8] == 24'h000000)
    else $error("upper address byte not zero");

  AST_KEY_READS_ZERO: assert property (@(posedge clk) disable iff (reset) // [RQ9]
    (avs_read && avs_address == `NVU_OFS_KEY && !s_r.rvalid)
    |=> avs_readdata == 32'h00000000)
    else $error("key register readable");

  AST_CTL_READBACK: assert property (@(posedge clk) disable iff (reset) // [RQ6]
    (avs_read && avs_address == `NVU_OFS_CONTROL && !s_r.rvalid)
    |=> avs_readdata[15:0] == $past(ctl_read))
    else $error("control read wrong");

  // bus timing: writes never wait, reads wait exactly one cycle
  AST_WAIT_READ_ONLY: assert property (@(posedge clk) disable iff (reset)
    (avs_write && !avs_read)
    |-> !avs_waitrequest)
    else $error("write was stalled");

  AST_READ_ANSWER: assert property (@(posedge clk) disable iff (reset)
    (avs_read && !s_r.rvalid)
    |=> s_r.rvalid)
    else $error("read not answered");

  AST_RVALID_ONE: assert property (@(posedge clk) disable iff (reset)
    s_r.rvalid
    |=> !s_r.rvalid)
    else $error("read answer held too long");

  AST_RDATA_STANDS: assert property (@(posedge clk) disable iff (reset)
    !(avs_read && !s_r.rvalid)
    |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  // reset behaviour is checked while reset is high, so no disable here
  AST_CTL_RESET: assert property (@(posedge clk) // [RQ6]
    $past(reset)
    |-> ctl_read == 16'h0000)
    else $error("control not reset");

  AST_RESET_CLEARS: assert property (@(posedge clk) // [RQ6]
    reset
    |=> !s_r.start && !s_r.write_enable_bit && !s_r.write_error_flag && s_r.optype == 4'h0 && !irq)
    else $error("reset left state behind");
endmodule : nvu_unlock_control

/* File: tb/tb.sv */
// self-checking bench for the nonvolatile unlock control
`timescale 1ns/1ps
`include "nvu_defines.svh"
module tb;
  import nvu_pkg::*;
  logic clk = 0, reset = 1, avs_read = 0, avs_write = 0, tbl_valid = 0;
  logic op_done = 0, abort_reset = 0, avs_waitrequest, op_start, irq, seen;
  logic [15:0] avs_address = 16'h0000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_val;
  logic [3:0] avs_byteenable = 4'hF, op_type;
  logic [23:0] tbl_address = 24'h0;
  int err_count = 0, num_checks = 0;
  always #5 clk = ~clk;
  nvu_unlock_control i_nvu_unlock_control (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tbl_valid(tbl_valid), .tbl_address(tbl_address), .op_done(op_done),
    .abort_reset(abort_reset), .op_start(op_start), .op_type(op_type), .irq(irq));
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one bus cycle; an idle edge follows so strobes never toggle twice in a step
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    // only the watchdog ends a wait that never comes back
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge clk);
    end
    seen = op_start;
    rd_val = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic pulse_done();
    op_done <= 1'b1;
    @(posedge clk);
    op_done <= 1'b0;
    @(posedge clk);
  endtask : pulse_done
  task automatic t_reset();
    bus(0, `NVU_OFS_CONTROL, 0);
    chk(rd_val, 32'h0000_0000);
    bus(0, `NVU_OFS_KEY, 0);
    chk(rd_val, 32'h0000_0000);
    bus(0, 16'h0770, 0);
    chk(rd_val, 32'h0000_0000);
    $display("test reset values done");
  endtask : t_reset
  task automatic t_capture();
    tbl_address <= 24'hABCDEF;
    tbl_valid <= 1'b1;
    @(posedge clk);
    tbl_valid <= 1'b0;
    @(posedge clk);
    bus(0, `NVU_OFS_ADDR_LOW, 0);
    chk(rd_val, 32'h0000_CDEF);
    bus(0, `NVU_OFS_ADDR_UPPER, 0);
    chk(rd_val, 32'h0000_00AB);
    $display("test address capture done");
  endtask : t_capture
  task automatic t_unlock();
    bus(1, `NVU_OFS_IRQ_MASK, 32'h1);
    bus(1, `NVU_OFS_CONTROL, 32'h4003);
    bus(1, `NVU_OFS_KEY, 32'h55);
    bus(1, `NVU_OFS_KEY, 32'hAA);
    bus(1, `NVU_OFS_CONTROL, 32'hC003);
    chk(seen, 1'b1);
    repeat (2) @(posedge clk);
    chk(op_type, 4'h3);
    bus(1, `NVU_OFS_CONTROL, 32'h4003);
    bus(0, `NVU_OFS_CONTROL, 0);
    chk(rd_val[15], 1'b1);
    pulse_done();
    bus(0, `NVU_OFS_CONTROL, 0);
    chk(rd_val, 32'h0000_4003);
    chk(irq, 1'b1);
    bus(1, `NVU_OFS_IRQ_STATUS, 32'h1);
    chk(irq, 1'b0);
    $display("test unlock and start done");
  endtask : t_unlock
  task automatic t_broken();
    bus(1, `NVU_OFS_KEY, 32'h55);
    bus(1, `NVU_OFS_ADDR_LOW, 32'h1234);
    bus(1, `NVU_OFS_KEY, 32'hAA);
    bus(1, `NVU_OFS_CONTROL, 32'hC003);
    chk(seen, 1'b0);
    bus(1, `NVU_OFS_KEY, 32'h56);
    bus(1, `NVU_OFS_KEY, 32'hAA);
    bus(1, `NVU_OFS_CONTROL, 32'hC003);
    chk(seen, 1'b0);
    bus(1, `NVU_OFS_KEY, 32'hAA);
    bus(1, `NVU_OFS_KEY, 32'h55);
    bus(1, `NVU_OFS_CONTROL, 32'hC003);
    chk(seen, 1'b0);
    bus(1, `NVU_OFS_KEY, 32'h55);
    bus(1, `NVU_OFS_KEY, 32'hAA);
    bus(1, `NVU_OFS_CONTROL, 32'hC003);
    chk(seen, 1'b1);
    abort_reset <= 1'b1;
    @(posedge clk);
    abort_reset <= 1'b0;
    bus(0, `NVU_OFS_CONTROL, 0);
    chk(rd_val[13], 1'b1);
    pulse_done();
    bus(1, `NVU_OFS_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    bus(1, `NVU_OFS_IRQ_MASK, 32'h2);
    chk(irq, 1'b1);
    bus(0, `NVU_OFS_IRQ_STATUS, 0);
    chk(rd_val, 32'h0000_0002);
    $display("test broken sequences done");
  endtask : t_broken
  task automatic t_midreset();
    bus(1, `NVU_OFS_CONTROL, 32'h4003);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(0, `NVU_OFS_CONTROL, 0);
    chk(rd_val, 32'h0000_0000);
    bus(0, `NVU_OFS_ADDR_UPPER, 0);
    chk(rd_val[31:8], 24'h000000);
    chk(irq, 1'b0);
    $display("test mid-run reset done");
  endtask : t_midreset
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_capture();
    t_unlock();
    t_broken();
    t_midreset();
    close_out();
  end
  // the whole sequence needs well under two thousand cycles
  initial
  begin
    #200000;
    err_count++;
    close_out();
  end
endmodule : tb
